//--- hw/output_compare_pwm_unit.sv
// output compare / pwm unit with an avalon-mm register slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module output_compare_pwm_unit
  import ocmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [31:0] timer_a_count,
  input  wire logic [31:0] timer_b_count,
  input  wire logic        cpu_idle,
  input  wire logic        fault_in_b,
  output logic             compare_output_pin,
  output logic             irq
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // byte lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // control word as software sees it
  function automatic logic [31:0] ctrl_pack(input ctrl_t c,
                                            input logic  flt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_ON]   = c.on;
    w[BIT_IDLE] = c.idle_stop;
    w[BIT_WIDE] = c.wide;
    w[BIT_FLT]  = flt && (c.mode == MODE_PWM_FLT);
    w[BIT_TSEL] = c.tsel;
    w[MODE_LSB +: 3] = c.mode;
    return w;
  endfunction

  // written word back into fields
  function automatic ctrl_t ctrl_unpack(input logic [31:0] w);
    ctrl_t c;
    c.on        = w[BIT_ON];
    c.idle_stop = w[BIT_IDLE];
    c.wide      = w[BIT_WIDE];
    c.tsel      = w[BIT_TSEL];
    c.mode      = w[MODE_LSB +: 3];
    return c;
  endfunction

  // pin level a mode starts from
  function automatic logic init_level(input logic [2:0] mode,
                                      input logic       cur);
    case (mode)
      MODE_SET_LO: init_level = 1'b1;
      MODE_TOGGLE: init_level = cur;
      default:     init_level = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ctrl_t            ctrl_q;
  logic [31:0]      pri_q;
  logic [31:0]      sec_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic             flt_s1_q;
  logic             flt_s2_q;
  logic             pin_q;
  logic             flag_q;
  logic             irq_q;
  logic [3:0]       key_q;
  pulse_st_t        ps_q;

  logic             pri_hit;
  logic             sec_hit;
  logic             wr_en;
  logic             susp;
  logic             active;
  logic             init;
  logic             fault_act;
  logic             flt_set;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic [31:0]      ctrl_wr;

  // ---------------------------------------------------------------
  // compare engine
  // ---------------------------------------------------------------

  count_comparator u_cmp (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .count_a (timer_a_count),
    .count_b (timer_b_count),
    .cfg     (ctrl_q),
    .pri_val (pri_q),
    .sec_val (sec_q),
    .pri_hit (pri_hit),
    .sec_hit (sec_hit)
  );

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------

  // accepting edge: request present and waitrequest already low
  assign wr_en = avs_write && !wait_q;

  // waitrequest drops for one cycle, one cycle after a request shows up
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read data captured as waitrequest falls; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      case (avs_address)
        OFF_CTRL: rdata_q <= ctrl_pack(ctrl_q, flag_q) & CTRL_RMASK;
        OFF_PRI:  rdata_q <= pri_q;
        OFF_SEC:  rdata_q <= sec_q;
        OFF_STAT: rdata_q <= {30'h0000_0000, stat_q};
        OFF_MASK: rdata_q <= {30'h0000_0000, mask_q};
        default:  rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // merged control word; the flag lane is masked out of the write
  assign ctrl_wr = be_merge(ctrl_pack(ctrl_q, 1'b0), avs_writedata,
                            avs_byteenable) & CTRL_WMASK;

  // control register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q <= ctrl_unpack(CTRL_RST);
    end else if (wr_en && avs_address == OFF_CTRL) begin
      ctrl_q <= ctrl_unpack(ctrl_wr);
    end
  end

  // compare value registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pri_q <= VAL_RST;
      sec_q <= VAL_RST;
    end else if (wr_en) begin
      if (avs_address == OFF_PRI) begin
        pri_q <= be_merge(pri_q, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_SEC) begin
        sec_q <= be_merge(sec_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // ---------------------------------------------------------------
  // fault input and operating conditions
  // ---------------------------------------------------------------

  // fault pin is asynchronous, two flops before use
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flt_s1_q <= 1'b1;
      flt_s2_q <= 1'b1;
    end else begin
      flt_s1_q <= fault_in_b;
      flt_s2_q <= flt_s1_q;
    end
  end

  assign fault_act = !flt_s2_q;

  assign susp   = ctrl_q.idle_stop && cpu_idle;
  assign active = ctrl_q.on && !susp && (ctrl_q.mode != MODE_OFF);

  // a change of enable or mode restarts the pin from the mode's level
  assign init = ctrl_q.on && ({ctrl_q.on, ctrl_q.mode} != key_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      key_q <= 4'h0;
    end else begin
      key_q <= {ctrl_q.on, ctrl_q.mode};
    end
  end

  // ---------------------------------------------------------------
  // pwm fault flag
  // ---------------------------------------------------------------

  assign flt_set = ctrl_q.on && (ctrl_q.mode == MODE_PWM_FLT) && !susp && fault_act;

  // set wins; hardware clears it on a secondary match once the fault has gone,
  // or when the mode leaves 111; the bus has no path to it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (flt_set) begin
      flag_q <= 1'b1;
    end else if (ctrl_q.mode != MODE_PWM_FLT) begin
      flag_q <= 1'b0;
    end else if (active && sec_hit && !fault_act) begin
      flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pulse sequencer
  // ---------------------------------------------------------------

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ps_q <= PS_WAIT;
    end else if (!ctrl_q.on || init) begin
      ps_q <= PS_WAIT;
    end else if (!susp) begin
      case (ps_q)
        PS_WAIT: begin
          if (pri_hit) begin
            ps_q <= PS_HIGH;
          end
        end
        PS_HIGH: begin
          if (sec_hit) begin
            ps_q <= (ctrl_q.mode == MODE_ONE_SHOT) ? PS_DONE : PS_WAIT;
          end
        end
        PS_DONE: ps_q <= PS_DONE;
        default: ps_q <= PS_WAIT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output pin
  // ---------------------------------------------------------------

  // priority: off, restart, idle hold, fault, then mode behaviour
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else if (!ctrl_q.on || ctrl_q.mode == MODE_OFF) begin
      pin_q <= 1'b0;
    end else if (init) begin
      pin_q <= init_level(ctrl_q.mode, pin_q);
    end else if (susp) begin
      pin_q <= pin_q;
    end else if (ctrl_q.mode == MODE_PWM_FLT && (flag_q || fault_act)) begin
      pin_q <= 1'b0;
    end else begin
      case (ctrl_q.mode)
        MODE_SET_HI: begin
          if (pri_hit) begin
            pin_q <= 1'b1;
          end
        end
        MODE_SET_LO: begin
          if (pri_hit) begin
            pin_q <= 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (pri_hit) begin
            pin_q <= !pin_q;
          end
        end
        MODE_ONE_SHOT, MODE_TRAIN: begin
          if (ps_q == PS_WAIT && pri_hit) begin
            pin_q <= 1'b1;
          end else if (ps_q == PS_HIGH && sec_hit) begin
            pin_q <= 1'b0;
          end
        end
        default: begin
          if (pri_hit) begin
            pin_q <= 1'b1;
          end else if (sec_hit) begin
            pin_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------

  assign ev[IRQ_CMP] = active && pri_hit;
  assign ev[IRQ_FLT] = flt_set && !flag_q;
  assign w1c = (wr_en && avs_address == OFF_STAT && avs_byteenable[0]) ?
               avs_writedata[IRQ_W-1:0] : IRQ_RST;

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_q <= IRQ_RST;
    end else begin
      stat_q <= (stat_q & ~w1c) | ev;
    end
  end

  // mask register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mask_q <= IRQ_RST;
    end else if (wr_en && avs_address == OFF_MASK && avs_byteenable[0]) begin
      mask_q <= avs_writedata[IRQ_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status it reflects
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign avs_readdata       = rdata_q;
  assign avs_waitrequest    = wait_q;
  assign compare_output_pin = pin_q;
  assign irq                = irq_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_off;
    !ctrl_q.on |=> !pin_q;
  endproperty
  a_off: assert property (p_off) else $error("pin high while disabled");

  property p_idle;
    (ctrl_q.on && ctrl_q.mode != MODE_OFF && susp && !init) |=> $stable(pin_q);
  endproperty
  a_idle: assert property (p_idle) else $error("pin moved in idle");

  property p_fault_hold;
    (flag_q && ctrl_q.mode == MODE_PWM_FLT && fault_act) |=> flag_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("flag lost");

  property p_flt_read;
    ($fell(wait_q) && $past(avs_read) && $past(avs_address) == OFF_CTRL &&
     $past(ctrl_q.mode) != MODE_PWM_FLT) |-> !rdata_q[BIT_FLT];
  endproperty
  a_flt_read: assert property (p_flt_read) else $error("flag read outside 111");

  property p_fault_set;
    (flt_set && !init) |=> (flag_q && !pin_q);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not caught");

  property p_no_flt;
    (ctrl_q.mode != MODE_PWM_FLT) |=> !flag_q;
  endproperty
  a_no_flt: assert property (p_no_flt) else $error("flag outside 111");

  property p_one_shot;
    (ps_q == PS_DONE && ctrl_q.mode == MODE_ONE_SHOT && !init) |=> !pin_q;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("second pulse");

  property p_toggle;
    (active && ctrl_q.mode == MODE_TOGGLE && pri_hit && !init) |=> pin_q != $past(pin_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_force_low;
    (active && ctrl_q.mode == MODE_SET_LO && pri_hit && !init) |=> !pin_q;
  endproperty
  a_force_low: assert property (p_force_low) else $error("not forced low");

  property p_force_high;
    (active && ctrl_q.mode == MODE_SET_HI && pri_hit && !init) |=> pin_q;
  endproperty
  a_force_high: assert property (p_force_high) else $error("not forced high");

  property p_reserved;
    ($fell(wait_q) && $past(avs_read) && $past(avs_address) == OFF_CTRL)
      |-> (rdata_q & ~CTRL_RMASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule

`default_nettype wire

//--- hw/ocmp_pkg.sv
// constants and types for the output compare unit
`default_nettype none

package ocmp_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_PRI  = 5'h04;
  localparam logic [4:0] OFF_SEC  = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0c;
  localparam logic [4:0] OFF_MASK = 5'h10;

  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_ON   = 15;
  localparam int BIT_IDLE = 13;
  localparam int BIT_WIDE = 5;
  localparam int BIT_FLT  = 4;
  localparam int BIT_TSEL = 3;
  localparam int MODE_LSB = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_a02f;
  localparam logic [31:0] CTRL_RMASK = 32'h0000_a03f;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] VAL_RST    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_SET_HI   = 3'h1;
  localparam logic [2:0] MODE_SET_LO   = 3'h2;
  localparam logic [2:0] MODE_TOGGLE   = 3'h3;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h4;
  localparam logic [2:0] MODE_TRAIN    = 3'h5;
  localparam logic [2:0] MODE_PWM      = 3'h6;
  localparam logic [2:0] MODE_PWM_FLT  = 3'h7;

  // ---------------------------------------------------------------
  // interrupt status layout
  // ---------------------------------------------------------------
  localparam int IRQ_CMP = 0;
  localparam int IRQ_FLT = 1;
  localparam int IRQ_W   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // control fields as they travel inside the block
  typedef struct packed {
    logic       on;
    logic       idle_stop;
    logic       wide;
    logic       tsel;
    logic [2:0] mode;
  } ctrl_t;

  // pulse sequencer for single and continuous pulse modes
  typedef enum logic [1:0] {PS_WAIT, PS_HIGH, PS_DONE} pulse_st_t;

endpackage

`default_nettype wire

//--- hw/count_comparator.sv
// equality detectors for the primary and secondary compare values
`timescale 1ns/1ps
`default_nettype none

module count_comparator
  import ocmp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] count_a,
  input  wire logic [31:0] count_b,
  input  wire ctrl_t       cfg,
  input  wire logic [31:0] pri_val,
  input  wire logic [31:0] sec_val,
  output logic             pri_hit,
  output logic             sec_hit
);

  // narrow compares ignore the upper half of both operands
  function automatic logic [31:0] fit(input logic [31:0] v,
                                      input logic        wide);
    return wide ? v : {16'h0000, v[15:0]};
  endfunction

  logic [31:0] sel_count;
  logic [1:0]  eq;
  logic [1:0]  eq_q;
  logic [1:0]  hit_q;
  logic [31:0] ref_val [2];

  assign sel_count  = cfg.tsel ? count_b : count_a;
  assign ref_val[0] = pri_val;
  assign ref_val[1] = sec_val;

  // one detector per compare value; a hit fires once, in the cycle after the first equal cycle,
  // so a stopped timer resting on the value does not retrigger
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    assign eq[i] = fit(sel_count, cfg.wide) == fit(ref_val[i], cfg.wide);
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        eq_q[i]  <= 1'b0;
        hit_q[i] <= 1'b0;
      end else begin
        eq_q[i]  <= eq[i];
        hit_q[i] <= eq[i] && !eq_q[i];
      end
    end
  end

  assign pri_hit = hit_q[0];
  assign sec_hit = hit_q[1];

endmodule

`default_nettype wire

//--- tb/pin_load.sv
// external load on the compare pin; it also drives the fault pin
`timescale 1ns/1ps
`default_nettype none

module pin_load (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       pin,
  input  wire logic       fault_req,
  output logic            fault_in_b,
  output logic [7:0]      rise_cnt
);
  logic       last_q;
  logic [7:0] cnt_q;

  // fault line idles high on its pull-up, pulled low only on request
  assign fault_in_b = ~fault_req;
  assign rise_cnt   = cnt_q;

  // count rising edges so the bench can tell one pulse from a train
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      last_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else begin
      last_q <= pin;
      if (pin && !last_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

//--- tb/tb_output_compare_pwm_unit.sv
// self-checking bench for the output compare unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end

module tb_output_compare_pwm_unit
  import ocmp_pkg::*;
;
  localparam logic [31:0] EN   = 32'h0000_8000;
  localparam logic [31:0] IDL  = 32'h0000_7777; // never a compare value
  localparam logic [31:0] PRI  = 32'h0001_0100;
  localparam logic [31:0] SEC  = 32'h0000_0200;
  logic        sys_clk;
  logic        rst_b;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_r;
  logic [31:0] ta;
  logic [31:0] tb_c;
  logic        idle;
  logic        fault_req;
  logic        fault_b;
  logic        pin;
  logic        irq;
  logic [7:0]  rises;
  logic [31:0] r;
  int          bad_count;
  int          checks;
  int          cyc;

  output_compare_pwm_unit output_compare_pwm_unit_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .timer_a_count(ta), .timer_b_count(tb_c), .cpu_idle(idle), .fault_in_b(fault_b),
    .compare_output_pin(pin), .irq(irq));
  pin_load pin_load_i (.sys_clk(sys_clk), .rst_b(rst_b), .pin(pin), .fault_req(fault_req),
    .fault_in_b(fault_b), .rise_cnt(rises));

  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // bus and stimulus helpers
  // ----------------------------------------------------------------
  // request held until waitrequest is seen low; read data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge sys_clk);
    wr <= w; rd <= !w; addr <= a; wdata <= d; be <= b;
    do @(posedge sys_clk); while (wait_r !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rreg(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // one-cycle visit of a count value; the pin settles two cycles later
  task automatic hit(input logic src_b, input logic [31:0] v);
    @(posedge sys_clk);
    if (src_b) tb_c <= v; else ta <= v;
    @(posedge sys_clk);
    tb_c <= IDL;
    ta   <= IDL;
    repeat (4) @(posedge sys_clk);
  endtask
  // one quiet cycle after clearing enable
  task automatic setup(input logic [31:0] c);
    wreg(OFF_CTRL, 32'h0);
    @(posedge sys_clk);
    wreg(OFF_PRI, PRI);
    wreg(OFF_SEC, SEC);
    wreg(OFF_CTRL, c);
    repeat (3) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rreg(OFF_CTRL); `CHK(r, CTRL_RST)
    rreg(OFF_PRI); `CHK(r, VAL_RST)
    wreg(OFF_CTRL, 32'hffff_ffff);
    rreg(OFF_CTRL); `CHK(r, 32'h0000_a02f)
    bus(1'b1, OFF_CTRL, 32'h0, 4'he);
    rreg(OFF_CTRL); `CHK(r, 32'h0000_002f)
    wreg(5'h14, 32'hffff_ffff);
    rreg(5'h14); `CHK(r, 32'h0)
    $display("test regs done");
  endtask

  task automatic t_levels();
    setup(EN | 32'h1); `CHK(pin, 1'b0)
    hit(1'b0, PRI); `CHK(pin, 1'b1)
    setup(EN | 32'h2); `CHK(pin, 1'b1)
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    setup(EN | 32'h3);
    hit(1'b0, PRI); `CHK(pin, 1'b1)
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    $display("test levels done");
  endtask

  // three pri/sec periods; pin starts low and ends low
  task automatic t_pulses(input logic [2:0] m, input logic [7:0] n);
    logic [7:0] n0;
    setup(EN | {29'h0, m});
    n0 = rises;
    `CHK(pin, 1'b0)
    repeat (3) begin
      hit(1'b0, PRI);
      hit(1'b0, SEC);
    end
    `CHK(rises - n0, n)
    `CHK(pin, 1'b0)
    $display("test pulses mode %0d done", m);
  endtask

  task automatic t_fault();
    setup(EN | 32'h7);
    hit(1'b0, PRI); `CHK(pin, 1'b1)
    fault_req <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK(pin, 1'b0)
    rreg(OFF_CTRL); `CHK(r, 32'h0000_8017)
    // a one written to the flag must not clear it
    wreg(OFF_CTRL, EN | 32'h17);
    rreg(OFF_CTRL); `CHK(r, 32'h0000_8017)
    rreg(OFF_STAT); `CHK(r[IRQ_FLT], 1'b1)
    fault_req <= 1'b0;
    // fault gone, next secondary match lets hardware clear the flag
    hit(1'b0, SEC);
    rreg(OFF_CTRL); `CHK(r, 32'h0000_8007)
    wreg(OFF_CTRL, EN | 32'h6);
    rreg(OFF_CTRL); `CHK(r, 32'h0000_8006)
    wreg(OFF_STAT, 32'h3);
    $display("test fault done");
  endtask

  task automatic t_gate();
    setup(EN);
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    setup(32'h1);
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    setup(EN | 32'h2001);
    idle <= 1'b1;
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    idle <= 1'b0;
    hit(1'b0, PRI); `CHK(pin, 1'b1)
    setup(EN | 32'h1);
    idle <= 1'b1;
    hit(1'b0, PRI); `CHK(pin, 1'b1)
    idle <= 1'b0;
    $display("test gate done");
  endtask

  task automatic t_source();
    setup(EN | 32'h9);
    hit(1'b0, PRI); `CHK(pin, 1'b0)
    hit(1'b1, 32'h0000_0100); `CHK(pin, 1'b1)
    setup(EN | 32'h29);
    hit(1'b1, 32'h0000_0100); `CHK(pin, 1'b0)
    hit(1'b1, PRI); `CHK(pin, 1'b1)
    $display("test source done");
  endtask

  task automatic t_irq();
    setup(EN | 32'h1);
    wreg(OFF_STAT, 32'h3);
    wreg(OFF_MASK, 32'h1);
    hit(1'b0, PRI); `CHK(irq, 1'b1)
    rreg(OFF_STAT); `CHK(r, 32'h1)
    wreg(OFF_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wreg(OFF_MASK, 32'h0);
    hit(1'b0, PRI); `CHK(irq, 1'b0)
    rreg(OFF_STAT); `CHK(r, 32'h1)
    $display("test irq done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    sys_clk = 1'b0; rst_b = 1'b0; addr = 5'h0; rd = 1'b0; wr = 1'b0;
    wdata = 32'h0; be = 4'hf; ta = IDL; tb_c = IDL; idle = 1'b0; fault_req = 1'b0;
    bad_count = 0; checks = 0; cyc = 0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_levels();
    t_pulses(3'h4, 8'h01);
    t_pulses(3'h5, 8'h03);
    fault_req <= 1'b1;
    t_pulses(3'h6, 8'h03);
    fault_req <= 1'b0;
    t_fault();
    t_gate();
    t_source();
    t_irq();
    final_report();
  end
endmodule

`default_nettype wire
